// [frs_defines.svh]
// Opcodes, frame lengths, reset values and parameter-area contents
`ifndef FRS_DEFINES_SVH
`define FRS_DEFINES_SVH

// Opcodes
`define FRS_OP_RESUME     8'h30
`define FRS_OP_NOP        8'h00
`define FRS_OP_RST_EN     8'h66
`define FRS_OP_RST        8'h99
`define FRS_OP_SFDP       8'h5a

// Clock counts within a frame
`define FRS_SPI_CMD_CLKS  6'h08
`define FRS_QPI_CMD_CLKS  6'h02
`define FRS_SPI_OP_LAST   6'h07
`define FRS_QPI_OP_LAST   6'h01
`define FRS_ADDR_FIRST    6'h08
`define FRS_ADDR_LAST     6'h1f
`define FRS_DUMMY_LAST    6'h27
`define FRS_CNT_MAX       6'h28

// Reset values
`define FRS_FLAG_RST      1'b0
`define FRS_CS_IDLE       1'b1
`define FRS_BIT_FIRST     3'h7

// Parameter-area layout
`define FRS_SFDP_LAST     24'h000017
`define FRS_SIG_B0        8'h53
`define FRS_SIG_B1        8'h46
`define FRS_SIG_B2        8'h44
`define FRS_SIG_B3        8'h50
`define FRS_REV_MINOR     8'h00
`define FRS_REV_MAJOR     8'h01
`define FRS_NUM_HDR       8'h01
`define FRS_UNUSED        8'hff
`define FRS_HDR0_ID       8'h00
`define FRS_HDR0_LEN      8'h09
`define FRS_HDR0_PTR      8'h30
`define FRS_HDR1_LEN      8'h04
`define FRS_HDR1_PTR      8'h60
`define FRS_PTR_HIGH      8'h00

`endif

// [frs_pkg.sv]
// Types shared by the resume, reset and parameter-area command logic
package frs_pkg;

    typedef enum logic [2:0] {
        FRS_CMD_NONE   = 3'b000,
        FRS_CMD_RESUME = 3'b001,
        FRS_CMD_NOP    = 3'b010,
        FRS_CMD_RST_EN = 3'b011,
        FRS_CMD_RST    = 3'b100,
        FRS_CMD_OTHER  = 3'b101
    } frs_cmd_e;

    // Summary of one finished frame, handed from the link to the core
    typedef struct packed {
        logic [5:0] clks;
        logic [7:0] spi_op;
        logic [7:0] qpi_op;
    } frs_frame_s;

    typedef struct packed {
        logic erase_suspend_flag;
        logic program_suspend_flag;
        logic busy;
        logic reset_enable_pending;
    } frs_status_s;

endpackage : frs_pkg

// [frs_cmd_ctrl.sv]
// Resume, no-operation, software reset and parameter-area read logic
//
// Overview of operation
// R1 - Opcode 30h in one framed command cycle resumes the suspended write.
// R2 - An accepted resume clears whichever suspend flag is set.
// R3 - Resume needs no prior write enable command.
// R4 - Host waits at least 1ms after resume before another suspend.
// R5 - Busy stays set while the resumed write runs; host polls or waits.
// R6 - Resume is ignored while performance enhance mode is active.
// R7 - No-operation only cancels a pending reset enable.
// R8 - Short opcodes take 8 clocks on one line or 2 clocks on four.
// R9 - Reset acts only directly after reset enable; anything else cancels.
// R10 - Software reset returns to standby with volatile state at defaults.
// R11 - Software reset during a write aborts that write.
// R12 - Host waits reset recovery time before selecting the device again.
// R13 - Parameter read: 5Ah, 3 address bytes, 1 dummy, then data out.
// R14 - Raising chip select ends the read and stops data drive.
// R15 - Bytes 00h to 03h return 53h, 46h, 44h, 50h.
// R16 - Byte 04h returns 00h, byte 05h returns 01h.
// R17 - Byte 06h returns 01h, two headers.
// R18 - First header: ID 00h, rev 1.0, length 09h, pointer 000030h.
// R19 - Second header: vendor ID, rev 1.0, length 04h, pointer 000060h.
// R20 - Address advances per byte; bytes 07h, 0Fh, 17h read FFh.
`timescale 1ns/1ps
`include "frs_defines.svh"

module frs_cmd_ctrl
    import frs_pkg::*;
#(
    // Arbitrary neutral value for the vendor header identifier
    parameter logic [7:0] VENDOR_ID = 8'h5e
) (
    input  logic        core_clk,
    input  logic        reset,
    input  logic        spi_clk,
    input  logic        cs_n,
    input  logic [3:0]  sio_in,
    output logic        so_out,
    output logic        so_oe,
    input  logic        qpi_mode,
    input  logic        perf_enhance_mode,
    input  logic        erase_suspend_evt,
    input  logic        program_suspend_evt,
    input  logic        write_done,
    output frs_status_s status,
    output logic        resume_pulse,
    output logic        soft_reset_pulse,
    output logic        write_abort_pulse
);

    // ---------------- Link side, on spi_clk ----------------

    logic        in_frame;
    logic        out_en;
    logic        frame_tgl;
    logic [5:0]  clks;
    logic [7:0]  shift_sr;
    logic [3:0]  first_nib;
    logic [7:0]  spi_op;
    logic [7:0]  qpi_op;
    logic        qpi_meta;
    logic        qpi_link;
    logic        is_sfdp;
    logic [23:0] addr;
    logic [23:0] ptr;
    logic [2:0]  bit_idx;
    logic [7:0]  cur_byte;
    logic [7:0]  next_op;

    function automatic logic [7:0] sfdp_byte(input logic [23:0] a);
        logic [7:0] b;
        b = `FRS_UNUSED;
        if (a <= `FRS_SFDP_LAST) begin
            case (a[4:0])
                5'h00:   b = `FRS_SIG_B0;
                5'h01:   b = `FRS_SIG_B1;
                5'h02:   b = `FRS_SIG_B2;
                5'h03:   b = `FRS_SIG_B3;
                5'h04:   b = `FRS_REV_MINOR;
                5'h05:   b = `FRS_REV_MAJOR;
                5'h06:   b = `FRS_NUM_HDR;
                5'h08:   b = `FRS_HDR0_ID;
                5'h09:   b = `FRS_REV_MINOR;
                5'h0a:   b = `FRS_REV_MAJOR;
                5'h0b:   b = `FRS_HDR0_LEN;
                5'h0c:   b = `FRS_HDR0_PTR;
                5'h0d:   b = `FRS_PTR_HIGH;
                5'h0e:   b = `FRS_PTR_HIGH;
                5'h10:   b = VENDOR_ID;
                5'h11:   b = `FRS_REV_MINOR;
                5'h12:   b = `FRS_REV_MAJOR;
                5'h13:   b = `FRS_HDR1_LEN;
                5'h14:   b = `FRS_HDR1_PTR;
                5'h15:   b = `FRS_PTR_HIGH;
                5'h16:   b = `FRS_PTR_HIGH;
                default: b = `FRS_UNUSED;
            endcase
        end
        return b;
    endfunction : sfdp_byte

    // Chip select high clears the frame flags at once, with no clock
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            out_en <= 1'b0; // [R14]
        end else if (is_sfdp && clks == `FRS_DUMMY_LAST) begin
            out_en <= 1'b1; // [R13]
        end
    end

    // One toggle per started frame, on its first clock
    // Link clock stops between frames; reset gives a known start
    always_ff @(posedge spi_clk or posedge reset) begin
        if (reset) begin
            frame_tgl <= 1'b0;
            clks      <= 6'h00;
        end else if (!in_frame) begin
            frame_tgl <= ~frame_tgl;
            clks      <= 6'h01;
        end else if (clks != `FRS_CNT_MAX) begin
            clks      <= clks + 6'h01; // [R8]
        end
    end

    // Quasi-static mode level, settles well before an opcode completes
    always_ff @(posedge spi_clk) begin
        qpi_meta <= qpi_mode;
        qpi_link <= qpi_meta;
    end

    assign next_op = {shift_sr[6:0], sio_in[0]};

    // Single-line bits use line 0 only; upper lines ignored in SPI
    always_ff @(posedge spi_clk) begin
        shift_sr <= next_op; // [R8]
        if (!in_frame) begin
            first_nib <= sio_in;
        end
        if (in_frame && clks == `FRS_QPI_OP_LAST) begin
            qpi_op <= {first_nib, sio_in}; // [R8]
        end
        if (in_frame && clks == `FRS_SPI_OP_LAST) begin
            spi_op <= next_op; // [R8]
        end
    end

    // Parameter read is single-line only
    always_ff @(posedge spi_clk) begin
        if (!in_frame) begin
            is_sfdp <= 1'b0;
        end else if (clks == `FRS_SPI_OP_LAST) begin
            is_sfdp <= !qpi_link && next_op == `FRS_OP_SFDP; // [R13]
        end
        if (is_sfdp && clks >= `FRS_ADDR_FIRST
                    && clks <= `FRS_ADDR_LAST) begin
            addr <= {addr[22:0], sio_in[0]}; // [R13]
        end
    end

    assign cur_byte = sfdp_byte(ptr); // [R15] [R16] [R17] [R18] [R19]

    // Data changes on the falling edge, host samples on the rising
    // Address runs past 17h without wrapping; those bytes read FFh
    always_ff @(negedge spi_clk or posedge reset) begin
        if (reset) begin
            so_out  <= 1'b0;
            bit_idx <= `FRS_BIT_FIRST;
            ptr     <= 24'h000000;
        end else if (!out_en) begin
            bit_idx <= `FRS_BIT_FIRST;
            ptr     <= addr;
        end else begin
            so_out  <= cur_byte[bit_idx];
            bit_idx <= bit_idx - 3'h1;
            if (bit_idx == 3'h0) begin
                ptr <= ptr + 24'h000001; // [R20]
            end
        end
    end

    // Combinational so the drive stops with chip select, not a clock later
    assign so_oe = out_en & ~cs_n; // [R14]

    // ---------------- Core side, on core_clk ----------------

    logic       cs_meta;
    logic       cs_sync;
    logic       cs_prev;
    logic       tgl_meta;
    logic       tgl_sync;
    logic       last_tgl;
    logic       frame_end;
    frs_frame_s frame;
    frs_cmd_e   cmd;
    logic       esf;
    logic       psf;
    logic       busy;
    logic       rst_pending;
    logic       resume_ok;
    logic       sw_reset;
    logic [1:0] susp_evt;
    logic [1:0] susp_flag;

    // Idle-level reset, so no false frame end follows reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cs_meta  <= `FRS_CS_IDLE;
            cs_sync  <= `FRS_CS_IDLE;
            cs_prev  <= `FRS_CS_IDLE;
        end else begin
            cs_meta  <= cs_n;
            cs_sync  <= cs_meta;
            cs_prev  <= cs_sync;
        end
    end

    always_ff @(posedge core_clk) begin
        tgl_meta <= frame_tgl;
        tgl_sync <= tgl_meta;
    end

    // A frame with no clock edges does not toggle and is ignored
    always_ff @(posedge core_clk) begin
        if (reset) begin
            last_tgl <= tgl_sync;
        end else if (frame_end) begin
            last_tgl <= tgl_sync;
        end
    end

    assign frame_end = cs_sync & ~cs_prev;

    // Link words are frozen while chip select is high, so they are
    // read directly once the synchronised rise is seen
    assign frame = '{clks: clks, spi_op: spi_op, qpi_op: qpi_op};

    // Short commands must end exactly on the opcode boundary
    function automatic logic short_len_ok(input logic       q,
                                          input logic [5:0] n);
        return q ? n == `FRS_QPI_CMD_CLKS
                 : n == `FRS_SPI_CMD_CLKS; // [R8]
    endfunction : short_len_ok

    // Short opcodes only; anything else counts as another command
    function automatic frs_cmd_e decode_short(input logic [7:0] op);
        frs_cmd_e c;
        c = FRS_CMD_OTHER;
        case (op)
            `FRS_OP_RESUME: c = FRS_CMD_RESUME; // [R1]
            `FRS_OP_NOP:    c = FRS_CMD_NOP; // [R7]
            `FRS_OP_RST_EN: c = FRS_CMD_RST_EN; // [R9]
            `FRS_OP_RST:    c = FRS_CMD_RST; // [R9]
            default:        c = FRS_CMD_OTHER;
        endcase
        return c;
    endfunction : decode_short

    always_comb begin
        cmd = FRS_CMD_NONE;
        if (frame_end && tgl_sync != last_tgl) begin
            cmd = FRS_CMD_OTHER;
            if (short_len_ok(qpi_mode, frame.clks)) begin // [R8]
                cmd = decode_short(qpi_mode ? frame.qpi_op
                                            : frame.spi_op); // [R1]
            end
        end
    end

    // Write enable latch is deliberately not consulted
    assign resume_ok = cmd == FRS_CMD_RESUME && (esf || psf)
                       && !perf_enhance_mode; // [R1] [R3] [R6]
    assign sw_reset  = cmd == FRS_CMD_RST && rst_pending; // [R9]

    assign susp_evt = {erase_suspend_evt, program_suspend_evt};

    // Suspend event wins over a resume in the same cycle
    generate
        for (genvar i = 0; i < 2; i++) begin : g_susp
            always_ff @(posedge core_clk) begin
                if (reset || sw_reset) begin
                    susp_flag[i] <= `FRS_FLAG_RST; // [R10]
                end else begin
                    susp_flag[i] <= susp_evt[i]
                                    | (susp_flag[i] & ~resume_ok); // [R2]
                end
            end
        end
    endgenerate

    assign esf = susp_flag[1];
    assign psf = susp_flag[0];

    // Busy follows the resumed write only; suspend or completion ends it
    always_ff @(posedge core_clk) begin
        if (reset || sw_reset) begin
            busy <= `FRS_FLAG_RST; // [R10]
        end else if (resume_ok) begin
            busy <= 1'b1; // [R5]
        end else if (write_done || erase_suspend_evt
                     || program_suspend_evt) begin
            busy <= 1'b0; // [R5]
        end
    end

    // Every finished frame but reset enable drops a pending enable
    always_ff @(posedge core_clk) begin
        if (reset || sw_reset) begin
            rst_pending <= `FRS_FLAG_RST;
        end else begin
            case (cmd)
                FRS_CMD_NONE:   rst_pending <= rst_pending;
                FRS_CMD_RST_EN: rst_pending <= 1'b1; // [R9]
                FRS_CMD_NOP:    rst_pending <= 1'b0; // [R7]
                default:        rst_pending <= 1'b0; // [R9]
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            resume_pulse      <= 1'b0;
            soft_reset_pulse  <= 1'b0;
            write_abort_pulse <= 1'b0;
        end else begin
            resume_pulse      <= resume_ok; // [R1]
            soft_reset_pulse  <= sw_reset; // [R10]
            write_abort_pulse <= sw_reset & busy; // [R11]
        end
    end

    assign status = '{erase_suspend_flag:   esf,
                      program_suspend_flag: psf,
                      busy:                 busy,
                      reset_enable_pending: rst_pending};

endmodule : frs_cmd_ctrl

// [frs_cmd_ctrl_asserts.sv]
// Checker for the resume, reset and parameter-read command logic
`timescale 1ns/1ps
module frs_cmd_ctrl_asserts
    import frs_pkg::*;
(
    input logic        core_clk,
    input logic        reset,
    input logic        cs_n,
    input logic        so_oe,
    input logic        perf_enhance_mode,
    input logic        erase_suspend_evt,
    input logic        program_suspend_evt,
    input logic        write_done,
    input frs_status_s status,
    input logic        resume_pulse,
    input logic        soft_reset_pulse,
    input logic        write_abort_pulse
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    chk_oe_with_cs: assert property (so_oe |-> !cs_n)
        else $error("data driven while deselected");
    chk_resume_clears: assert property (
        resume_pulse && !$past(erase_suspend_evt || program_suspend_evt
        || write_done) |-> !status.erase_suspend_flag
        && !status.program_suspend_flag && status.busy)
        else $error("resume left a suspend flag or no busy");
    chk_busy_by_resume: assert property (
        $rose(status.busy) |-> resume_pulse)
        else $error("busy rose without a resume");
    chk_perf_blocks: assert property (perf_enhance_mode &&
        $past(perf_enhance_mode) && $past(perf_enhance_mode, 2)
        |-> !resume_pulse)
        else $error("resume taken in performance mode");
    chk_rst_needs_en: assert property (soft_reset_pulse |->
        $past(status.reset_enable_pending))
        else $error("reset without pending enable");
    chk_rst_clears: assert property (soft_reset_pulse |->
        !status.reset_enable_pending && !status.busy
        && !status.erase_suspend_flag && !status.program_suspend_flag)
        else $error("state survived software reset");
    chk_abort_busy: assert property (soft_reset_pulse |->
        write_abort_pulse == $past(status.busy))
        else $error("abort does not follow busy");
    chk_abort_only_rst: assert property (
        write_abort_pulse |-> soft_reset_pulse)
        else $error("abort without reset");
    chk_idle_pending: assert property (cs_n [*8] |=>
        $stable(status.reset_enable_pending))
        else $error("pending enable moved while idle");
    chk_pulse_single: assert property (resume_pulse |=> !resume_pulse)
        else $error("resume pulse too long");

    cov_resume: cover property (resume_pulse);
    cov_reset: cover property (soft_reset_pulse);
    cov_abort: cover property (write_abort_pulse);
    cov_read: cover property (so_oe);
endmodule : frs_cmd_ctrl_asserts

bind frs_cmd_ctrl frs_cmd_ctrl_asserts frs_cmd_ctrl_asserts_inst (
    .core_clk(core_clk), .reset(reset), .cs_n(cs_n), .so_oe(so_oe),
    .perf_enhance_mode(perf_enhance_mode),
    .erase_suspend_evt(erase_suspend_evt),
    .program_suspend_evt(program_suspend_evt), .write_done(write_done),
    .status(status), .resume_pulse(resume_pulse),
    .soft_reset_pulse(soft_reset_pulse),
    .write_abort_pulse(write_abort_pulse));

// [frs_host_model.sv]
// Host model: frames commands and parameter reads on the serial link
`timescale 1ns/1ps
module frs_host_model (
    output logic       spi_clk,
    output logic       cs_n,
    output logic [3:0] sio_in,
    input  logic       so_out
);
    logic [7:0] rxq[$];
    logic [7:0] sh;

    initial begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        sio_in = 4'h0;
    end

    // Output bit taken just before the rise, long after the falling shift
    task automatic tick(input logic [3:0] d, output logic b);
        sio_in = d;
        #7.5;
        b = so_out;
        spi_clk = 1'b1;
        #7.5;
        spi_clk = 1'b0;
    endtask : tick

    task automatic frame(input logic [39:0] bits, input int n,
                         input logic q, input int nrd);
        logic b;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
            tick(q ? bits[39-4*i -: 4] : {3'($urandom), bits[39-i]}, b);
        for (int i = 0; i < nrd; i++) begin
            tick(4'h0, b);
            sh = {sh[6:0], b};
            if (i % 8 == 7)
                rxq.push_back(sh);
        end
        #3;
        cs_n = 1'b1;
        sio_in = ~sio_in;
        #60;
    endtask : frame
endmodule : frs_host_model

// [test_frs_cmd_ctrl.sv]
// Self-checking bench for the resume, reset and parameter-read logic
`timescale 1ns/1ps
module test_frs_cmd_ctrl;
    import frs_pkg::*;
    localparam logic [7:0] VID = 8'h3c; // Arbitrary vendor code
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        spi_clk, cs_n, so_out, so_oe, rp, sp, ap;
    logic [3:0]  sio_in;
    logic        qpi = 1'b0;
    logic        perf = 1'b0;
    logic        oe_seen = 1'b0;
    localparam int RESET_RECOVERY_TIME = 20; // Core cycles, plain default
    logic [2:0]  ev = 3'h0;
    frs_status_s status;
    logic [15:0] expq[$];
    int          err_total = 0;
    int          checks = 0;
    logic [7:0]  tbl [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
        8'hff, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff, VID,
        8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hff};

    always #5 core_clk = ~core_clk;

    frs_cmd_ctrl #(.VENDOR_ID(VID)) frs_cmd_ctrl_inst (
        .core_clk(core_clk), .reset(reset), .spi_clk(spi_clk), .cs_n(cs_n),
        .sio_in(sio_in), .so_out(so_out), .so_oe(so_oe), .qpi_mode(qpi),
        .perf_enhance_mode(perf), .erase_suspend_evt(ev[0]),
        .program_suspend_evt(ev[1]), .write_done(ev[2]), .status(status),
        .resume_pulse(rp), .soft_reset_pulse(sp), .write_abort_pulse(ap));
    frs_host_model frs_host_model_inst (
        .spi_clk(spi_clk), .cs_n(cs_n), .sio_in(sio_in), .so_out(so_out));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic take(input logic [15:0] seen);
        check(seen, expq.size() > 0 ? expq.pop_front() : 16'hffff);
    endtask : take

    // Pulses and read bytes both land here, in the order they appear
    always @(negedge core_clk) begin
        if (so_oe)
            oe_seen = 1'b1;
        if (rp || sp || ap)
            take({8'h01, 1'b0, rp, sp, ap, status});
        while (frs_host_model_inst.rxq.size() > 0)
            take({8'h00, frs_host_model_inst.rxq.pop_front()});
    end

    // Internal suspend and write-done events; the host sends no suspend command
    task automatic fire(input logic [2:0] v);
        @(negedge core_clk);
        ev = v;
        @(negedge core_clk);
        ev = 3'h0;
    endtask : fire

    task automatic send(input logic [7:0] op, input int n, input logic q,
                        input logic [3:0] p, input logic [3:0] s);
        if (p[3])
            expq.push_back({8'h01, 1'b0, p[2:0], s});
        frs_host_model_inst.frame({op, 32'h0}, n, q, 0);
        repeat (8) @(negedge core_clk);
    endtask : send

    initial begin
        #500us;
        err_total++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h9a0b2f99));
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        check({12'h0, status}, 16'h0);
        fire(3'b001);
        send(8'h30, 8, 1'b0, 4'hc, 4'h2);
        fire(3'b100);
        check({12'h0, status}, 16'h0);
        fire(3'b010);
        qpi = 1'b1;
        send(8'h30, 2, 1'b1, 4'hc, 4'h2);
        qpi = 1'b0;
        fire(3'b100);
        fire(3'b001);
        perf = 1'b1;
        send(8'h30, 8, 1'b0, 4'h0, 4'h0);
        check({12'h0, status}, 16'h0008);
        perf = 1'b0;
        send(8'h30, 8, 1'b0, 4'hc, 4'h2);
        fire(3'b010);
        send(8'h30, 9, 1'b0, 4'h0, 4'h0);
        check({12'h0, status}, 16'h0004);
        send(8'h66, 8, 1'b0, 4'h0, 4'h0);
        check({12'h0, status}, 16'h0005);
        send(8'h00, 8, 1'b0, 4'h0, 4'h0);
        check({12'h0, status}, 16'h0004);
        send(8'h66, 8, 1'b0, 4'h0, 4'h0);
        send(8'hc0 | 8'($urandom), 8, 1'b0, 4'h0, 4'h0);
        send(8'h99, 8, 1'b0, 4'h0, 4'h0);
        check({12'h0, status}, 16'h0004);
        send(8'h30, 8, 1'b0, 4'hc, 4'h2);
        qpi = 1'b1;
        send(8'h66, 2, 1'b1, 4'h0, 4'h0);
        send(8'h99, 2, 1'b1, 4'hb, 4'h0);
        qpi = 1'b0;
        repeat (RESET_RECOVERY_TIME) @(negedge core_clk);
        check({15'h0, oe_seen}, 16'h0000);
        for (int i = 0; i < 24; i++)
            expq.push_back({8'h00, tbl[i]});
        frs_host_model_inst.frame({8'h5a, 32'h0}, 40, 1'b0, 192);
        check({15'h0, oe_seen}, 16'h0001);
        expq.push_back({8'h00, tbl[22]});
        expq.push_back({8'h00, tbl[23]});
        expq.push_back(16'h00ff);
        frs_host_model_inst.frame({8'h5a, 24'h16, 8'h0}, 40, 1'b0, 27);
        check({15'h0, so_oe}, 16'h0);
        for (int i = 0; i < 300 && expq.size() > 0; i++)
            @(negedge core_clk);
        if (expq.size() > 0)
            err_total++;
        stop_test();
    end
endmodule : test_frs_cmd_ctrl
